//--- tag_ctrl_regs.vh
// Constants for the contactless tag control block: register map, config
// field positions, field clock counts and the programming time.
// Assumes bit 1 of a memory block is stored in word bit 31 (first sent).
`ifndef TAG_CTRL_REGS_VH
`define TAG_CTRL_REGS_VH

// Avalon register byte offsets
`define REG_CTRL        5'h00
`define REG_STATUS      5'h04
`define REG_CONFIG      5'h08
`define REG_MEM_INDEX   5'h0c
`define REG_MEM_DATA    5'h10
`define REG_MEM_LOCK    5'h14

// Mode register fields (block bit n sits at word bit 32-n)
`define CFG_KEY_HI      31
`define CFG_KEY_LO      28
`define CFG_XMODE       17
`define CFG_MOD_HI      16
`define CFG_MOD_LO      12
`define CFG_AOR         9
`define CFG_LAST_BLOCK_LIMIT_HI   7
`define CFG_LAST_BLOCK_LIMIT_LO   5
`define CFG_PWD         4
`define CFG_ST          3
`define CFG_PORDLY      0
`define CFG_RESET       32'h00148000
`define MOD_MANCHESTER  5'h08
`define KEY_NO_TEST     4'h6

// Timing in field clocks
`define FC_CONFIG       14'd192
`define FC_POR_DELAY    14'd8190
`define FC_BIT          7'd64
`define FC_D0_MIN       7'd16
`define FC_D0_MAX       7'd31
`define FC_D1_MIN       7'd48
`define FC_D1_MAX       7'd63
`define FC_TIMEOUT      7'd64

// Valid command lengths in bits
`define LEN_RESET       7'd2
`define LEN_DIRECT      7'd6
`define LEN_WAKE        7'd34
`define LEN_STD         7'd38
`define LEN_PWD_WRITE   7'd70

// Programming cycle time
`define PROG_TIME_US    5600
`define CLK_MHZ         25
`define PROG_CYCLES     (`PROG_TIME_US * `CLK_MHZ)

`endif

//--- tag_ctrl.v
// Tag control: init, read streaming, command decoding, passwords, programming.
// Assumes field_tick pulses once per field clock; field_gap is synchronous.
// Behaviour
// - Config load 192 field clocks, damping held
// - Optional 8190 clock damped delay, then read
// - Gap during init restarts whole init
// - Regular read sends block 1 to limit
// - Limit 0..7; 0 sends config block
// - Each read entry starts with one 0
// - Direct access opcode, 0, address selects block
// - Password direct access; mismatch returns regular read
// - Page 1 block 0 config; 3-7 zeros
// - Terminator four ones, periods 2,4 special
// - Terminator only when enabled and not extended
// - Terminator precedes each read cycle
// - Gap intervals decode 24 as 0, 54 as 1
// - Over 64 clocks without gap ends write
// - Start gap accepted after load; receive damping on
// - Two-bit opcode; 00 resets, 1x selects page
// - Test writes ignored when master key is 6
// - Invalid command resumes read on last page
// - Password compared with block 7; mismatch skips programming
// - Answer-on-request waits for wake-up password
// - Programming success enters block read of block
// - Locked block skips programming except test writes, sends block
// - Verify failure stops modulation until next command
// - Mode register reloaded each block and reset
// - Valid lengths 70,38,34,38,6,2 bits
//
// Design decisions made here: the address map and register access over Avalon-MM.
`timescale 1ns/100ps
`include "tag_ctrl_regs.vh"

module tag_ctrl #(
   parameter PROG_CYCLES = `PROG_CYCLES   // Programming cycle in mclk cycles
) (
   input  wire        mclk,
   input  wire        sys_rst,
   input  wire        field_tick,
   input  wire        field_gap,
   input  wire [4:0]  avs_address,
   input  wire        avs_read,
   input  wire        avs_write,
   input  wire [31:0] avs_writedata,
   output reg  [31:0] avs_readdata,
   output reg         avs_waitrequest,
   output reg         load_damp,
   output reg         mod_enable,
   output reg         tx_data,
   output reg         prog_active
);

   ////////////////////////////////////////////////////////////////////////
   // Declarations
   localparam S_INIT   = 3'd0;           // Config load period
   localparam S_PORDLY = 3'd1;           // Optional power-on delay
   localparam S_READ   = 3'd2;           // Streaming memory
   localparam S_RX     = 3'd3;           // Receiving command
   localparam S_PROG   = 3'd4;           // Programming cycle
   localparam S_SILENT = 3'd5;           // No modulation

   localparam P_LEAD = 2'd0;             // Single leading 0
   localparam P_TERM = 2'd1;             // Terminator periods
   localparam P_DATA = 2'd2;             // Block data

   reg  [31:0] mem_word [0:15];          // Page 0 in 0..7, page 1 in 8..15
   reg  [15:0] mem_lock;                 // Lock bit per block
   reg  [31:0] cfg;                      // Mode register
   reg  [2:0]  state;                    // Main state
   reg  [13:0] init_cnt;                 // Init field clock count
   reg         gap_d;                    // Gap level last cycle
   reg  [6:0]  gap_int;                  // Field clocks since last gap
   reg  [69:0] rx_shift;                 // Received bits, newest in bit 0
   reg  [6:0]  rx_cnt;                   // Received bit count
   reg         rx_err;                   // Bad interval seen
   reg         page;                     // Page from last page opcode
   reg         blk_mode;                 // Block-read instead of regular
   reg  [2:0]  sel_blk;                  // Block for block-read
   reg         awake;                    // Woken by answer-on-request
   reg  [1:0]  phase;                    // Stream phase
   reg  [1:0]  term_idx;                 // Terminator period index
   reg  [2:0]  blk;                      // Block being sent
   reg  [4:0]  bit_idx;                  // Bit within block
   reg  [6:0]  bit_tmr;                  // Field clocks in bit period
   reg  [17:0] prog_tmr;                 // Programming cycle timer
   reg  [3:0]  prog_idx;                 // Memory index being programmed
   reg  [31:0] prog_data;                // Data being programmed
   reg         prog_lock;                // Lock bit being programmed
   reg         force_vfail;              // Software verify-fail control
   reg  [3:0]  mem_index;                // Software memory pointer
   reg  [31:0] cur_word;                 // Word of block being sent
   reg         next_bit;                 // Data value for this period
   reg         next_mod;                 // Modulation for this period

   wire        gap_start = field_gap & ~gap_d;
   wire        pwd_on    = cfg[`CFG_PWD];
   wire        aor_on    = cfg[`CFG_AOR];
   wire [2:0]  last_block_limit    = cfg[`CFG_LAST_BLOCK_LIMIT_HI:`CFG_LAST_BLOCK_LIMIT_LO];
   wire        manch     = (cfg[`CFG_MOD_HI:`CFG_MOD_LO] == `MOD_MANCHESTER);
   wire        st_on     = cfg[`CFG_ST] & ~cfg[`CFG_XMODE];
   wire        test_ok   = (cfg[`CFG_KEY_HI:`CFG_KEY_LO] != `KEY_NO_TEST);
   wire [2:0]  start_blk = blk_mode ? sel_blk : ((last_block_limit == 3'd0) ? 3'd0 : 3'd1);
   wire [2:0]  last_blk  = blk_mode ? sel_blk : last_block_limit;
   wire        bit_end   = field_tick && (bit_tmr == `FC_BIT - 7'd1);
   wire        is_d0     = (gap_int >= `FC_D0_MIN) && (gap_int <= `FC_D0_MAX);
   wire        is_d1     = (gap_int >= `FC_D1_MIN) && (gap_int <= `FC_D1_MAX);

   // Command fields for each valid length
   wire [1:0]  op2   = rx_shift[1:0];
   wire [1:0]  op6   = rx_shift[5:4];
   wire [1:0]  op34  = rx_shift[33:32];
   wire [1:0]  op38  = rx_shift[37:36];
   wire [1:0]  op70  = rx_shift[69:68];
   wire        pw34  = (rx_shift[31:0] == mem_word[7]);
   wire        pw38  = (rx_shift[35:4] == mem_word[7]);
   wire        pw70  = (rx_shift[67:36] == mem_word[7]);
   wire [1:0]  opw   = (rx_cnt == `LEN_PWD_WRITE) ? op70 : op38;
   ////////////////////////////////////////////////////////////////////////
   // Word of the block now being sent, page 1 mapped
   always @* begin
      if (!page || blk_mode == 1'b0 && page == 1'b0) begin
         cur_word = mem_word[{1'b0, blk}];
      end else if (blk == 3'd0) begin
         cur_word = mem_word[0];
      end else if (blk >= 3'd3) begin
         cur_word = 32'h00000000;
      end else begin
         cur_word = mem_word[{1'b1, blk}];
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // Value and modulation for the current bit period
   always @* begin
      next_bit = 1'b0;
      next_mod = 1'b1;
      case (phase)
         P_LEAD: begin
            next_bit = 1'b0;
         end
         P_TERM: begin
            next_bit = 1'b1;
            if (term_idx[0]) begin
               next_mod = manch;
            end
         end
         default: begin
            next_bit = cur_word[5'd31 - bit_idx];
         end
      endcase
   end
   ////////////////////////////////////////////////////////////////////////
   // Main control: init, streaming, reception, command execution
   always @(posedge mclk) begin
      if (sys_rst) begin
         state     <= S_INIT;
         cfg       <= `CFG_RESET;
         init_cnt  <= 14'd0;
         gap_d     <= 1'b0;
         gap_int   <= 7'd0;
         rx_cnt    <= 7'd0;
         page      <= 1'b0;
         blk_mode  <= 1'b0;
         sel_blk   <= 3'd0;
         awake     <= 1'b0;
         phase     <= P_LEAD;
         bit_tmr   <= 7'd0;
         prog_tmr  <= 18'd0;
      end else begin
         gap_d <= field_gap;
         case (state)
            // Load config with damping; a gap restarts the count
            S_INIT: begin
               if (gap_start) begin
                  init_cnt <= 14'd0;
               end else if (field_tick) begin
                  if (init_cnt == `FC_CONFIG - 14'd1) begin
                     init_cnt <= 14'd0;
                     cfg      <= mem_word[0];
                     state    <= mem_word[0][`CFG_PORDLY] ? S_PORDLY : S_READ;
                     blk_mode <= 1'b0;
                     phase    <= P_LEAD;
                     bit_tmr  <= 7'd0;
                     if (!mem_word[0][`CFG_PORDLY] && mem_word[0][`CFG_AOR]) begin
                        state <= S_SILENT;
                     end
                  end else begin
                     init_cnt <= init_cnt + 14'd1;
                  end
               end
            end
            // Power-on delay with permanent damping
            S_PORDLY: begin
               if (gap_start) begin
                  init_cnt <= 14'd0;
                  state    <= S_INIT;
               end else if (field_tick) begin
                  if (init_cnt == `FC_POR_DELAY - 14'd1) begin
                     init_cnt <= 14'd0;
                     state    <= aor_on ? S_SILENT : S_READ;
                  end else begin
                     init_cnt <= init_cnt + 14'd1;
                  end
               end
            end
            // Stream memory; a start gap opens reception
            S_READ, S_SILENT: begin
               if (gap_start) begin
                  state   <= S_RX;
                  gap_int <= 7'd0;
                  rx_cnt  <= 7'd0;
                  rx_err  <= 1'b0;
               end else if (state == S_READ && field_tick) begin
                  bit_tmr <= bit_tmr + 7'd1;
                  if (bit_end) begin
                     bit_tmr <= 7'd0;
                     case (phase)
                        P_LEAD: begin
                           phase    <= st_on ? P_TERM : P_DATA;
                           term_idx <= 2'd0;
                           blk      <= start_blk;
                           bit_idx  <= 5'd0;
                           cfg      <= mem_word[0];
                        end
                        P_TERM: begin
                           term_idx <= term_idx + 2'd1;
                           if (term_idx == 2'd3) begin
                              phase <= P_DATA;
                           end
                        end
                        default: begin
                           bit_idx <= bit_idx + 5'd1;
                           if (bit_idx == 5'd31) begin
                              cfg <= mem_word[0];
                              if (blk == last_blk) begin
                                 blk <= start_blk;
                                 if (st_on) begin
                                    phase    <= P_TERM;
                                    term_idx <= 2'd0;
                                 end
                              end else begin
                                 blk <= blk + 3'd1;
                              end
                           end
                        end
                     endcase
                  end
               end
            end
            // Decode gap intervals into bits until timeout
            S_RX: begin
               if (gap_start) begin
                  gap_int <= 7'd0;
                  if (is_d0 || is_d1) begin
                     rx_shift <= {rx_shift[68:0], is_d1};
                     if (rx_cnt != 7'd127) begin
                        rx_cnt <= rx_cnt + 7'd1;
                     end
                  end else if (gap_int != 7'd0) begin
                     rx_err <= 1'b1;
                  end
               end else if (field_tick) begin
                  if (gap_int == `FC_TIMEOUT) begin
                     gap_int  <= 7'd0;
                     state    <= S_READ;
                     blk_mode <= 1'b0;
                     phase    <= P_LEAD;
                     bit_tmr  <= 7'd0;
                     if (aor_on && !awake) begin
                        state <= S_SILENT;
                     end
                     if (rx_err) begin
                        rx_cnt <= 7'd0;
                     end else if (rx_cnt == `LEN_RESET) begin
                        if (op2 == 2'b00) begin
                           state    <= S_INIT;
                           init_cnt <= 14'd0;
                        end else if (op2[1]) begin
                           page <= op2[0];
                        end
                     end else if (rx_cnt == `LEN_DIRECT && !pwd_on && op6[1] && !rx_shift[3]) begin
                        page     <= op6[0];
                        blk_mode <= 1'b1;
                        sel_blk  <= rx_shift[2:0];
                     end else if (rx_cnt == `LEN_WAKE && pwd_on && op34 == 2'b10) begin
                        awake <= pw34;
                        state <= (pw34 || !aor_on) ? S_READ : S_SILENT;
                     end else if (rx_cnt == `LEN_STD && pwd_on && op38[1] && !rx_shift[3]) begin
                        if (pw38) begin
                           page     <= op38[0];
                           blk_mode <= 1'b1;
                           sel_blk  <= rx_shift[2:0];
                        end else begin
                           awake <= 1'b0;
                        end
                     end else if ((rx_cnt == `LEN_STD && !pwd_on && (op38[1] || (op38 == 2'b01 && test_ok)))
                                  || (rx_cnt == `LEN_PWD_WRITE && pwd_on && op70[1] && pw70)) begin
                        prog_lock <= rx_shift[35];
                        prog_data <= rx_shift[34:3];
                        prog_idx  <= {(opw[1] & opw[0]), rx_shift[2:0]};
                        page      <= opw[1] ? opw[0] : page;
                        sel_blk   <= rx_shift[2:0];
                        blk_mode  <= 1'b1;
                        if (mem_lock[{(opw[1] & opw[0]), rx_shift[2:0]}] && opw[1]) begin
                           state <= S_READ;
                        end else begin
                           state    <= S_PROG;
                           prog_tmr <= 18'd0;
                        end
                     end else if (rx_cnt == `LEN_PWD_WRITE && pwd_on && !pw70) begin
                        awake <= 1'b0;
                     end
                  end else begin
                     gap_int <= gap_int + 7'd1;
                  end
               end
            end
            // Hold for the programming time, then verify
            S_PROG: begin
               prog_tmr <= prog_tmr + 18'd1;
               if (prog_tmr == PROG_CYCLES[17:0] - 18'd1) begin
                  bit_tmr <= 7'd0;
                  phase   <= P_LEAD;
                  if (force_vfail || mem_word[prog_idx] != prog_data) begin
                     state <= S_SILENT;
                  end else begin
                     state <= S_READ;
                  end
               end
            end
            default: begin
               state <= S_INIT;
            end
         endcase
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // Memory: software load port and end of programming write
   always @(posedge mclk) begin
      if (state == S_PROG && prog_tmr == PROG_CYCLES[17:0] - 18'd2) begin
         mem_word[prog_idx] <= prog_data;
         mem_lock[prog_idx] <= prog_lock;
      end else if (avs_write && !avs_waitrequest && avs_address == `REG_MEM_DATA) begin
         mem_word[mem_index] <= avs_writedata;
      end else if (avs_write && !avs_waitrequest && avs_address == `REG_MEM_LOCK) begin
         mem_lock[mem_index] <= avs_writedata[0];
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // Registered outputs toward the modulator and front end
   always @(posedge mclk) begin
      if (sys_rst) begin
         load_damp   <= 1'b1;
         mod_enable  <= 1'b0;
         tx_data     <= 1'b0;
         prog_active <= 1'b0;
      end else begin
         load_damp   <= (state == S_INIT) || (state == S_PORDLY) || (state == S_RX);
         mod_enable  <= (state == S_READ) && next_mod;
         tx_data     <= (state == S_READ) && next_bit;
         prog_active <= (state == S_PROG);
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // Avalon slave: one wait cycle, then answer
   always @(posedge mclk) begin
      if (sys_rst) begin
         avs_waitrequest <= 1'b1;
         avs_readdata    <= 32'h00000000;
         force_vfail     <= 1'b0;
         mem_index       <= 4'd0;
      end else begin
         avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
         if (avs_write && !avs_waitrequest) begin
            if (avs_address == `REG_CTRL) begin
               force_vfail <= avs_writedata[0];
            end else if (avs_address == `REG_MEM_INDEX) begin
               mem_index <= avs_writedata[3:0];
            end
         end
         if (avs_read && avs_waitrequest) begin
            if (avs_address == `REG_CTRL) begin
               avs_readdata <= {31'd0, force_vfail};
            end else if (avs_address == `REG_STATUS) begin
               avs_readdata <= {9'd0, rx_cnt, 4'd0, sel_blk, blk_mode, page, awake, 3'd0, state};
            end else if (avs_address == `REG_CONFIG) begin
               avs_readdata <= cfg;
            end else if (avs_address == `REG_MEM_INDEX) begin
               avs_readdata <= {28'd0, mem_index};
            end else if (avs_address == `REG_MEM_DATA) begin
               avs_readdata <= mem_word[mem_index];
            end else if (avs_address == `REG_MEM_LOCK) begin
               avs_readdata <= {31'd0, mem_lock[mem_index]};
            end else begin
               avs_readdata <= 32'h00000000;
            end
         end
      end
   end

endmodule // tag_ctrl

//--- tag_reader.sv
// Reader model: free-running field clock, gap sequences.
// Assumes bits are sent MSB first, start gap first.
`timescale 1ns/100ps
module tag_reader (
   input  logic mclk,
   output logic field_tick,
   output logic field_gap
);
   logic [1:0] div = 2'h0; // Field clock is mclk/4
   initial {field_tick, field_gap} = 2'b00;
   // One field tick every fourth mclk
   always @(posedge mclk) begin
      div <= div + 2'h1;
      field_tick <= (div == 2'h3);
   end
   task automatic ticks(input int n);
      repeat (n) @(posedge mclk iff field_tick);
   endtask
   // Gap of 8 field clocks
   task automatic gap();
      field_gap <= 1'b1;
      ticks(8);
      field_gap <= 1'b0;
   endtask
   // Gap to gap is 24 for a 0, 54 for a 1
   task automatic send(input logic [69:0] bits, input int n);
      gap();
      for (int i = n - 1; i >= 0; i--) begin
         ticks(bits[i] ? 46 : 16);
         gap();
      end
      ticks(80);
   endtask
endmodule // tag_reader

//--- tag_ctrl_chk.sv
// Port checker for tag_ctrl.
// Assumes one clock, sync reset high.
`timescale 1ns/100ps
module tag_ctrl_chk (
   input logic        mclk,
   input logic        sys_rst,
   input logic        field_gap,
   input logic [4:0]  avs_address,
   input logic        avs_read,
   input logic        avs_write,
   input logic [31:0] avs_readdata,
   input logic        avs_waitrequest,
   input logic        load_damp,
   input logic        mod_enable,
   input logic        tx_data,
   input logic        prog_active
);
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);
   property p_ans; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
   a_ans: assert property (p_ans) else $error("bus not answered");
   property p_one; !avs_waitrequest |=> avs_waitrequest; endproperty
   a_one: assert property (p_one) else $error("ready held");
   property p_idle; !avs_read && !avs_write |=> avs_waitrequest; endproperty
   a_idle: assert property (p_idle) else $error("ready when idle");
   property p_unm; avs_read && avs_waitrequest && avs_address > 5'h14 |=> avs_readdata == 32'h0; endproperty
   a_unm: assert property (p_unm) else $error("unmapped read not zero");
   property p_init; $fell(sys_rst) |-> load_damp [*8]; endproperty
   a_init: assert property (p_init) else $error("no damping at init");
   property p_gap; $rose(field_gap) && load_damp |=> load_damp [*8]; endproperty
   a_gap: assert property (p_gap) else $error("damping dropped at gap");
   property p_excl; !(load_damp && mod_enable); endproperty
   a_excl: assert property (p_excl) else $error("damp and modulate");
   property p_lead; $rose(mod_enable) && !$past(tx_data) |-> !tx_data; endproperty
   a_lead: assert property (p_lead) else $error("lead bit not zero");
   property p_prog; prog_active |-> !mod_enable && !load_damp; endproperty
   a_prog: assert property (p_prog) else $error("streaming while programming");
   c_prog: cover property ($fell(prog_active));
   c_mod: cover property ($rose(mod_enable));
   c_rd: cover property (avs_read && !avs_waitrequest);
   c_gap: cover property ($rose(field_gap) && load_damp);
endmodule // tag_ctrl_chk
bind tag_ctrl tag_ctrl_chk tag_ctrl_chk_i (.mclk(mclk), .sys_rst(sys_rst), .field_gap(field_gap),
   .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .load_damp(load_damp), .mod_enable(mod_enable), .tx_data(tx_data),
   .prog_active(prog_active));

//--- testbench.sv
// Self-checking bench for tag_ctrl.
// Assumes reader model drives the field lines.
`timescale 1ns/100ps
`include "tag_ctrl_regs.vh"
module testbench;
   logic mclk = 1'b0;
   logic sys_rst, avs_read, avs_write;
   logic [4:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, rd;
   logic avs_waitrequest, load_damp, mod_enable, tx_data, prog_active, field_tick, field_gap;
   int failures = 0, tests_run = 0;
   always #20 mclk = ~mclk;
   tag_reader tag_reader_i (.mclk(mclk), .field_tick(field_tick), .field_gap(field_gap));
   tag_ctrl #(.PROG_CYCLES(20)) tag_ctrl_i (.mclk(mclk), .sys_rst(sys_rst), .field_tick(field_tick),
      .field_gap(field_gap), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .load_damp(load_damp), .mod_enable(mod_enable), .tx_data(tx_data), .prog_active(prog_active));
   task automatic check(input string nm, input logic [31:0] exp, got);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("BAD %s exp %h got %h", nm, exp, got);
      end
   endtask
   // Avalon access, held until waitrequest is seen low
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= !wr;
      avs_write <= wr;
      do @(posedge mclk); while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic t_init();
      sys_rst <= 1'b1;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      avs_address <= 5'h00;
      avs_writedata <= 32'h0;
      repeat (10) @(posedge mclk);
      sys_rst <= 1'b0;
      bus(1, `REG_MEM_INDEX, 32'h0);
      bus(1, `REG_MEM_DATA, 32'h20); // Limit 1, no terminator
      bus(1, `REG_MEM_INDEX, 32'h1);
      bus(1, `REG_MEM_DATA, 32'h80000000);
      bus(1, `REG_MEM_INDEX, 32'h2);
      bus(1, `REG_MEM_LOCK, 32'h0); // Block 2 writable
      bus(0, 5'h1c, 32'h0);
      check("unmapped", 32'h0, rd);
      tag_reader_i.ticks(100);
      tag_reader_i.gap();
      tag_reader_i.ticks(120);
      check("damp", 32'h1, {31'h0, load_damp});
      for (int n = 0; n < 3000 && mod_enable !== 1'b1; n++) @(posedge mclk);
      tag_reader_i.ticks(32);
      check("lead", 32'h0, {31'h0, tx_data});
      tag_reader_i.ticks(64);
      check("bit1", 32'h1, {31'h0, tx_data});
      tag_reader_i.ticks(64);
      check("bit2", 32'h0, {31'h0, tx_data});
   endtask
   // Page 1 direct access to block 1, then a short invalid frame
   task automatic t_cmds();
      tag_reader_i.send(8'b110001, 6);
      bus(0, `REG_STATUS, 32'h0);
      check("direct", 32'h3a, {rd[11:7], rd[2:0]});
      tag_reader_i.send(8'b110, 3);
      bus(0, `REG_STATUS, 32'h0);
      check("invalid", 32'h2a, {rd[11:7], rd[2:0]});
      tag_reader_i.send({2'b10, 1'b0, 32'h96c35a0f, 3'b010}, 38);
      bus(0, `REG_STATUS, 32'h0);
      check("written", 32'h52, {rd[11:7], rd[2:0]});
      bus(1, `REG_MEM_INDEX, 32'h2);
      bus(0, `REG_MEM_DATA, 32'h0);
      check("data", 32'h96c35a0f, rd);
      tag_reader_i.send(8'b00, 2);
      tag_reader_i.ticks(10);
      check("reset", 32'h1, {31'h0, load_damp & !mod_enable});
   endtask
   task automatic tally_and_finish();
      if (failures == 0 && tests_run > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      t_init();
      t_cmds();
      tally_and_finish();
   end
   // Watchdog
   initial begin
      #(40 * 40000);
      failures++;
      tally_and_finish();
   end
endmodule // testbench
